// ---- verilog/wls_status_bank.sv ----
// Status bank holding wake input levels, strap levels and sticky high-side fault flags.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - Bit7 shows development strap level
// - Bit6 shows interrupt pin pull-up strap
// - Bits5,4 show general pins 2,1
// - Bit3 of level register reads zero
// - General pin levels refresh in Normal/Stop
// - Cyclic-sense wake levels update per sample
// - General pins never use sampled reporting
// - Pin level shown even as switch
// - Overload flags per switch, upper zero
// - Open-load flags per switch, upper zero
// - Reset clears faults, restart keeps them
// - Reset zeroes bits five and four
module wls_status_bank (
    input  wire logic                              mclk,
    input  wire logic                              rst_n,
    input  wire logic                              soft_reset,
    input  wire logic                              restart,
    input  wire logic [3:0]                        op_mode,
    input  wire logic                              fail_out3_test_pin,
    input  wire logic                              int_pullup_config_strap,
    input  wire logic [wls_pkg::NUM_GP-1:0]        gp_pin_in,
    input  wire logic [wls_pkg::NUM_GP-1:0]        gp_sel_gpio,
    input  wire logic [wls_pkg::NUM_GP-1:0]        gp_cfg_wake_or_switch,
    input  wire logic [wls_pkg::NUM_WAKE-1:0]      wake_pin_in,
    input  wire logic [wls_pkg::NUM_WAKE-1:0]      wake_cyclic_mode,
    input  wire logic [wls_pkg::NUM_WAKE-1:0]      wake_sample_strobe,
    input  wire logic [wls_pkg::NUM_SWITCH-1:0]    switch_overload_det,
    input  wire logic [wls_pkg::NUM_SWITCH-1:0]    switch_openload_det,
    input  wire logic                              reg_rd,
    input  wire logic                              reg_clr,
    input  wire logic [6:0]                        reg_addr,
    output var  logic [7:0]                        reg_rdata
);
    // Pin levels after the two-flop synchroniser.
    localparam int NPIN = wls_pkg::NUM_WAKE + wls_pkg::NUM_GP + 2;
    logic [NPIN-1:0]                   pins_sync;
    logic [wls_pkg::NUM_WAKE-1:0]      wake_s;
    logic [wls_pkg::NUM_GP-1:0]        gp_s;
    logic                              dev_s;
    logic                              pull_s;
    // Level register fields and their next values.
    logic [wls_pkg::NUM_WAKE-1:0]      wake_in_level;
    logic [wls_pkg::NUM_WAKE-1:0]      next_wake_in_level;
    logic [wls_pkg::NUM_GP-1:0]        gp_pin_level;
    logic [wls_pkg::NUM_GP-1:0]        next_gp_pin_level;
    logic                              development_strap_level;
    logic                              next_development_strap_level;
    logic                              pullup_level;
    logic                              next_pullup_level;
    // Sticky fault flags.
    logic [wls_pkg::NUM_SWITCH-1:0]    overload_flags;
    logic [wls_pkg::NUM_SWITCH-1:0]    next_overload_flags;
    logic [wls_pkg::NUM_SWITCH-1:0]    openload_flags;
    logic [wls_pkg::NUM_SWITCH-1:0]    next_openload_flags;
    logic [7:0]                        next_reg_rdata;
    logic                              run_mode;
    logic                              clear_all;

    // Address match used by the read mux and the clear decode.
    function automatic logic addr_is(input logic [6:0] a, input logic [6:0] ref_addr);
        addr_is = (a == ref_addr);
    endfunction

    // All asynchronous pins pass through one synchroniser bank.
    wls_sync2 #(
        .WIDTH (NPIN)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({fail_out3_test_pin, int_pullup_config_strap, gp_pin_in, wake_pin_in}),
        .sync_out (pins_sync)
    );

    assign wake_s = pins_sync[wls_pkg::NUM_WAKE-1:0];
    assign gp_s   = pins_sync[wls_pkg::NUM_WAKE+wls_pkg::NUM_GP-1:wls_pkg::NUM_WAKE];
    assign pull_s = pins_sync[NPIN-2];
    assign dev_s  = pins_sync[NPIN-1];

    // General pin levels follow their configured pins in Normal and Stop; faults clear on power-on, soft reset or a host clear, never on restart.
    assign run_mode  = (op_mode == wls_pkg::WLS_MODE_NORMAL) || (op_mode == wls_pkg::WLS_MODE_STOP);
    assign clear_all = soft_reset;

    // Next values of the level fields.
    always_comb
    begin
        next_development_strap_level = dev_s;
        next_pullup_level            = pull_s;
        next_gp_pin_level            = gp_pin_level;
        next_wake_in_level           = wake_in_level;
        for (int i = 0; i < wls_pkg::NUM_GP; i++)
        begin
            // General pins are never sampled, so they track the live level while refreshed.
            if (run_mode && (gp_sel_gpio[i] || gp_cfg_wake_or_switch[i]))
            begin
                next_gp_pin_level[i] = gp_s[i];
            end
        end
        for (int i = 0; i < wls_pkg::NUM_WAKE; i++)
        begin
            if (!wake_cyclic_mode[i])
            begin
                next_wake_in_level[i] = wake_s[i];
            end
            else if (wake_sample_strobe[i])
            begin
                // Sampled level is kept until the next sampling event.
                next_wake_in_level[i] = wake_s[i];
            end
        end
        if (clear_all)
        begin
            next_gp_pin_level = '0;
        end
    end

    // Next values of the sticky fault flags; a new detection wins over a host clear.
    always_comb
    begin
        next_overload_flags = overload_flags;
        next_openload_flags = openload_flags;
        if (reg_clr && addr_is(reg_addr, wls_pkg::ADDR_OVERLOAD))
        begin
            next_overload_flags = wls_pkg::FLAGS_CLEAR;
        end
        if (reg_clr && addr_is(reg_addr, wls_pkg::ADDR_OPENLOAD))
        begin
            next_openload_flags = wls_pkg::FLAGS_CLEAR;
        end
        next_overload_flags = next_overload_flags | switch_overload_det;
        next_openload_flags = next_openload_flags | switch_openload_det;
        if (clear_all)
        begin
            // Restart is deliberately absent here so flags survive it.
            next_overload_flags = wls_pkg::FLAGS_CLEAR;
            next_openload_flags = wls_pkg::FLAGS_CLEAR;
        end
    end

    // Read data mux; the answer is registered one cycle after the read strobe.
    always_comb
    begin
        next_reg_rdata = reg_rdata;
        if (reg_rd)
        begin
            if (addr_is(reg_addr, wls_pkg::ADDR_WAKE_LEVEL))
            begin
                next_reg_rdata = '0;
                next_reg_rdata[wls_pkg::BIT_DEV_STRAP] = development_strap_level;
                next_reg_rdata[wls_pkg::BIT_PULLUP]    = pullup_level;
                next_reg_rdata[wls_pkg::BIT_GP2]       = gp_pin_level[1];
                next_reg_rdata[wls_pkg::BIT_GP1]       = gp_pin_level[0];
                next_reg_rdata[wls_pkg::BIT_RSVD]      = 1'b0;
                next_reg_rdata[wls_pkg::BIT_WAKE3]     = wake_in_level[2];
                next_reg_rdata[wls_pkg::BIT_WAKE2]     = wake_in_level[1];
                next_reg_rdata[wls_pkg::BIT_WAKE1]     = wake_in_level[0];
            end
            else if (addr_is(reg_addr, wls_pkg::ADDR_OVERLOAD))
            begin
                next_reg_rdata = {wls_pkg::UPPER_ZERO, overload_flags};
            end
            else if (addr_is(reg_addr, wls_pkg::ADDR_OPENLOAD))
            begin
                next_reg_rdata = {wls_pkg::UPPER_ZERO, openload_flags};
            end
            else
            begin
                // Addresses outside this bank read as zero.
                next_reg_rdata = wls_pkg::READ_UNMAPPED;
            end
        end
    end

    // State registers; power-on reset clears all.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            development_strap_level <= 1'b0;
            pullup_level            <= 1'b0;
            gp_pin_level            <= '0;
            wake_in_level           <= '0;
            overload_flags          <= wls_pkg::FLAGS_CLEAR;
            openload_flags          <= wls_pkg::FLAGS_CLEAR;
            reg_rdata               <= wls_pkg::FAULT_RESET;
        end
        else
        begin
            development_strap_level <= next_development_strap_level;
            pullup_level            <= next_pullup_level;
            gp_pin_level            <= next_gp_pin_level;
            wake_in_level           <= next_wake_in_level;
            overload_flags          <= next_overload_flags;
            openload_flags          <= next_openload_flags;
            reg_rdata               <= next_reg_rdata;
        end
    end

    // Detection sets a flag in the next cycle whatever else happens, bar reset.
    a_overload_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (switch_overload_det[0] && !soft_reset) |=> overload_flags[0])
        else $error("overload flag not set");
    a_openload_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (switch_openload_det[3] && !soft_reset) |=> openload_flags[3])
        else $error("open-load flag not set");
    // Flags do not drop without a clear or reset.
    a_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        (overload_flags[1] && !soft_reset && !reg_clr) |=> overload_flags[1])
        else $error("overload flag dropped on its own");
    a_restart_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
        (restart && !soft_reset && !reg_clr && openload_flags[2]) |=> openload_flags[2])
        else $error("restart cleared a flag");
    // Soft reset wins over a detection in the same cycle, as a reset should.
    a_soft_clears: assert property (@(posedge mclk) disable iff (!rst_n)
        soft_reset |=> (overload_flags == wls_pkg::FLAGS_CLEAR && openload_flags == wls_pkg::FLAGS_CLEAR
                        && gp_pin_level == '0))
        else $error("soft reset left bits set");
    a_level_rsvd: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == wls_pkg::ADDR_WAKE_LEVEL) |=> (reg_rdata[wls_pkg::BIT_RSVD] == 1'b0))
        else $error("reserved bit nonzero");
    a_fault_upper: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && (reg_addr == wls_pkg::ADDR_OVERLOAD || reg_addr == wls_pkg::ADDR_OPENLOAD))
        |=> (reg_rdata[7:wls_pkg::NUM_SWITCH] == wls_pkg::UPPER_ZERO))
        else $error("upper fault bits nonzero");
    a_wake_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (wake_cyclic_mode[0] && !wake_sample_strobe[0]) |=> $stable(wake_in_level[0]))
        else $error("sampled wake level changed without sample");
    a_strap_track: assert property (@(posedge mclk) disable iff (!rst_n)
        (fail_out3_test_pin ##1 fail_out3_test_pin ##1 fail_out3_test_pin) |=> development_strap_level)
        else $error("strap level not followed");
endmodule
`default_nettype wire

// ---- pkg/wls_pkg.sv ----
// Package with register map, field positions and reset values of the wake level and high-side fault bank.
package wls_pkg;
    // Register addresses on the 7-bit serial address field.
    localparam logic [6:0] ADDR_WAKE_LEVEL = 7'h48;
    localparam logic [6:0] ADDR_OVERLOAD   = 7'h54;
    localparam logic [6:0] ADDR_OPENLOAD   = 7'h55;
    // Field positions in the wake input level register.
    localparam int BIT_DEV_STRAP = 7;
    localparam int BIT_PULLUP    = 6;
    localparam int BIT_GP2       = 5;
    localparam int BIT_GP1       = 4;
    localparam int BIT_RSVD      = 3;
    localparam int BIT_WAKE3     = 2;
    localparam int BIT_WAKE2     = 1;
    localparam int BIT_WAKE1     = 0;
    // Number of high-side switches, of wake inputs and of general pins.
    localparam int NUM_SWITCH = 4;
    localparam int NUM_WAKE   = 3;
    localparam int NUM_GP     = 2;
    // Reset values.
    localparam logic [7:0] FAULT_RESET   = 8'h00;
    localparam logic [3:0] FLAGS_CLEAR   = 4'h0;
    localparam logic [3:0] UPPER_ZERO    = 4'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // Operating mode codes that the mode controller presents.
    typedef enum logic [3:0] {
        WLS_MODE_NORMAL  = 4'h1,
        WLS_MODE_STOP    = 4'h2,
        WLS_MODE_SLEEP   = 4'h4,
        WLS_MODE_RESTART = 4'h8
    } wls_mode_e;
endpackage

// ---- verilog/wls_sync2.sv ----
// Two-flop synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/100ps
`default_nettype none
module wls_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    // First stage is read only by the second stage.
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // Next values simply shift the pin level along the chain.
    always_comb
    begin
        next_meta = async_in;
        next_sync = meta;
    end

    // Both stages clear on synchronous reset.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= next_meta;
            sync_out <= next_sync;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/wls_host.sv ----
// Host model that reads and clears the status bank registers.
`timescale 1ns/100ps
`default_nettype none
module wls_host (
    input  wire logic       mclk,
    output var  logic       reg_rd,
    output var  logic       reg_clr,
    output var  logic [6:0] reg_addr,
    input  wire logic [7:0] reg_rdata
);
    // Idle strobes low; the address is scrambled between accesses so no stale value helps.
    initial
    begin
        reg_rd   = 1'b0;
        reg_clr  = 1'b0;
        reg_addr = 7'h7F;
    end

    // One read strobe; the answer is taken one cycle after the read edge.
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge mclk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask

    // One clear strobe; besides power-on and soft reset, only the host clears the sticky flags.
    task automatic clr(input logic [6:0] a);
        @(posedge mclk);
        #1;
        reg_clr  = 1'b1;
        reg_addr = a;
        @(posedge mclk);
        #1;
        reg_clr  = 1'b0;
        reg_addr = ~a;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the wake level and high-side fault status bank.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module tb;
    logic       mclk = 1'b0;    // Core clock, 4 ns period.
    logic       rst_n = 1'b0;   // Power-on reset, active low.
    logic       soft_reset, restart, dev, pull;
    logic [3:0] op_mode, ovl_det, opl_det, exp_ovl, exp_opl;
    logic [1:0] gp_in, gp_sel, gp_cfg, exp_gp;
    logic [2:0] wk_in, wk_cyc, wk_stb, exp_wk;
    logic       reg_rd, reg_clr;
    logic [6:0] reg_addr;
    logic [7:0] reg_rdata, rd_data;
    int         failures = 0;
    int         comparisons = 0;

    // Free-running clock.
    always #2 mclk = ~mclk;

    wls_status_bank wls_status_bank_i (.mclk(mclk), .rst_n(rst_n), .soft_reset(soft_reset), .restart(restart),
        .op_mode(op_mode), .fail_out3_test_pin(dev), .int_pullup_config_strap(pull), .gp_pin_in(gp_in),
        .gp_sel_gpio(gp_sel), .gp_cfg_wake_or_switch(gp_cfg), .wake_pin_in(wk_in), .wake_cyclic_mode(wk_cyc),
        .wake_sample_strobe(wk_stb), .switch_overload_det(ovl_det), .switch_openload_det(opl_det),
        .reg_rd(reg_rd), .reg_clr(reg_clr), .reg_addr(reg_addr), .reg_rdata(reg_rdata));
    wls_host wls_host_i (.mclk(mclk), .reg_rd(reg_rd), .reg_clr(reg_clr), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata));

    // Counts, verdict and end of run; shared by the main sequence and the watchdog.
    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Let n edges pass, then step just off the edge before driving.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Read one register and compare with the model value.
    task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
        wls_host_i.rd(a, rd_data);
        `CHK("reg_rdata", e, rd_data)
    endtask

    // Model of the level register built from the bench's own pin history.
    function automatic logic [7:0] lvl();
        return {dev, pull, exp_gp, 1'b0, exp_wk};
    endfunction

    // Hang guard; the whole sequence needs well under a thousand cycles.
    initial
    begin
        #(5000 * 4);
        failures++;
        final_report();
    end

    initial
    begin
        {soft_reset, restart, ovl_det, opl_det, gp_sel, gp_cfg, wk_cyc, wk_stb} = '0;
        op_mode = wls_pkg::WLS_MODE_SLEEP;
        {dev, pull, gp_in, wk_in} = {1'b1, 1'b0, 2'b11, 3'b101};
        {exp_gp, exp_wk, exp_ovl, exp_opl} = {2'b00, 3'b101, 4'h0, 4'h0};
        void'($urandom(32'h3eca6889));
        tick(5);
        rst_n = 1'b1;
        // Reset state: gp bits zero while no refresh mode is active, faults clear.
        tick(4);
        chk_rd(wls_pkg::ADDR_WAKE_LEVEL, lvl());
        chk_rd(wls_pkg::ADDR_OVERLOAD, 8'h00);
        chk_rd(wls_pkg::ADDR_OPENLOAD, 8'h00);
        $display("TEST reset values done");
        // Normal mode, pins both GPIO and switch; then Stop with only pin1 configured.
        op_mode = wls_pkg::WLS_MODE_NORMAL;
        {gp_sel, gp_cfg} = 4'hF;
        exp_gp = 2'b11;
        tick(4);
        chk_rd(wls_pkg::ADDR_WAKE_LEVEL, lvl());
        op_mode = wls_pkg::WLS_MODE_STOP;
        {gp_sel, gp_cfg, gp_in} = 6'h04;
        exp_gp = 2'b10;
        tick(4);
        chk_rd(wls_pkg::ADDR_WAKE_LEVEL, lvl());
        $display("TEST gp refresh done");
        // Random strap, wake and gp levels with continuous reporting.
        op_mode = wls_pkg::WLS_MODE_NORMAL;
        gp_sel = 2'b11;
        repeat (8)
        begin
            {dev, pull, gp_in, wk_in} = 7'($urandom());
            {exp_gp, exp_wk} = {gp_in, wk_in};
            tick(4);
            chk_rd(wls_pkg::ADDR_WAKE_LEVEL, lvl());
        end
        $display("TEST random levels done");
        // Sampled reporting: level holds until its own sample strobe.
        wk_cyc = 3'b111;
        wk_in = ~exp_wk;
        tick(4);
        chk_rd(wls_pkg::ADDR_WAKE_LEVEL, lvl());
        wk_stb = 3'b001;
        tick(1);
        wk_stb = 3'b000;
        exp_wk[0] = wk_in[0];
        tick(2);
        chk_rd(wls_pkg::ADDR_WAKE_LEVEL, lvl());
        $display("TEST cyclic sense done");
        // Sticky flags: one-cycle detections accumulate and survive a restart.
        // Overload switch 2 and open-load switch 3 are always hit so the sticky and restart checks see a set flag.
        repeat (3)
        begin
            {ovl_det, opl_det} = 8'($urandom()) | 8'h24;
            {exp_ovl, exp_opl} = {exp_ovl | ovl_det, exp_opl | opl_det};
            tick(1);
            {ovl_det, opl_det} = 8'h00;
            chk_rd(wls_pkg::ADDR_OVERLOAD, {4'h0, exp_ovl});
            chk_rd(wls_pkg::ADDR_OPENLOAD, {4'h0, exp_opl});
        end
        {restart, op_mode} = {1'b1, wls_pkg::WLS_MODE_RESTART};
        tick(1);
        {restart, op_mode} = {1'b0, wls_pkg::WLS_MODE_NORMAL};
        chk_rd(wls_pkg::ADDR_OVERLOAD, {4'h0, exp_ovl});
        chk_rd(wls_pkg::ADDR_OPENLOAD, {4'h0, exp_opl});
        wls_host_i.clr(wls_pkg::ADDR_WAKE_LEVEL);
        chk_rd(wls_pkg::ADDR_OPENLOAD, {4'h0, exp_opl});
        wls_host_i.clr(wls_pkg::ADDR_OVERLOAD);
        chk_rd(wls_pkg::ADDR_OVERLOAD, 8'h00);
        chk_rd(wls_pkg::ADDR_OPENLOAD, {4'h0, exp_opl});
        // Open-load clear while switch 4 still detects: the detection in the clear cycle wins.
        opl_det = 4'h8;
        exp_opl = 4'h8;
        wls_host_i.clr(wls_pkg::ADDR_OPENLOAD);
        opl_det = 4'h0;
        chk_rd(wls_pkg::ADDR_OPENLOAD, {4'h0, exp_opl});
        chk_rd(7'h30, wls_pkg::READ_UNMAPPED);
        $display("TEST sticky flags done");
        // Soft reset clears faults and gp bits; Sleep keeps gp from refreshing.
        {ovl_det, op_mode} = {4'h5, wls_pkg::WLS_MODE_SLEEP};
        tick(1);
        {ovl_det, soft_reset} = {4'h0, 1'b1};
        tick(1);
        soft_reset = 1'b0;
        exp_gp = 2'b00;
        chk_rd(wls_pkg::ADDR_OVERLOAD, 8'h00);
        chk_rd(wls_pkg::ADDR_OPENLOAD, 8'h00);
        chk_rd(wls_pkg::ADDR_WAKE_LEVEL, lvl());
        $display("TEST soft reset done");
        final_report();
    end
endmodule
`default_nettype wire
